// >>> shared/fault_pkg.sv
// Shared constants, types and reset values of the fault monitor and trouble-code reporter
package fault_pkg;

  // Clock and time base
  localparam int CLK_HZ = 10_000_000;          // System clock rate
  localparam int TICK_US = 1000;               // Evaluation tick period in microseconds
  localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
  localparam int PERIOD_MS = 1000;             // Idle active-code message period
  localparam int STARTUP_MS = 5000;            // Broadcast hold-off after power-up
  localparam int PERIOD_TICKS = (PERIOD_MS * 1000) / TICK_US;
  localparam int STARTUP_TICKS = (STARTUP_MS * 1000) / TICK_US;

  // Sizes
  localparam int NUM_DEF = 16;                 // Diagnostic definitions
  localparam int NUM_TH = 4;                   // Thresholds (channels) per definition
  localparam int NUM_CH = NUM_DEF * NUM_TH;    // Trouble-code channels
  localparam int NUM_SRC = 8;                  // Monitored value inputs
  localparam int VAL_W = 16;                   // Monitored value width
  localparam int SPN_W = 19;                   // Suspect parameter number width
  localparam int FMI_W = 5;                    // Failure mode identifier width
  localparam int OC_W = 7;                     // Occurrence count width
  localparam int DELAY_W = 16;                 // Persist delay width, in ticks
  localparam int CNT_W = 16;                   // Timer counter width

  // Trouble-code fields
  localparam logic CONV_METHOD = 1'b0;         // Conversion method is always zero
  localparam logic [OC_W-1:0] OC_MAX = 7'h7F;  // Occurrence count saturates here

  // Monitored source indices
  localparam logic [2:0] SRC_SUPPLY = 3'h0;
  localparam logic [2:0] SRC_TEMP = 3'h1;
  localparam logic [2:0] SRC_COMM_TIMEOUT = 3'h2;

  // Default thresholds after a configuration reset
  localparam logic [VAL_W-1:0] SUPPLY_LOW_TH = 16'h2328;
  localparam logic [VAL_W-1:0] SUPPLY_HIGH_TH = 16'h7530;
  localparam logic [VAL_W-1:0] TEMP_HIGH_TH = 16'h0055;
  localparam logic [VAL_W-1:0] STATE_ON_TH = 16'h0001;   // Fixed state-style threshold
  localparam logic [DELAY_W-1:0] DEFAULT_DELAY = 16'h0064;

  // Fault styles
  typedef enum logic [1:0] {STYLE_MINMAX, STYLE_ABS, STYLE_STATE, STYLE_DOUBLE} fault_style_t;

  // Per-definition configuration
  typedef struct packed {
    logic enable;
    logic [2:0] source;
    fault_style_t style;
  } def_cfg_t;

  // Per-threshold reporting configuration
  typedef struct packed {
    logic [VAL_W-1:0] threshold;
    logic [SPN_W-1:0] fault_parameter_number_setting;
    logic [FMI_W-1:0] fmi;
    logic [DELAY_W-1:0] fault_persist_delay;
    logic sticky_until_clear_option;
  } chan_cfg_t;

  // Per-channel fault state
  typedef struct packed {
    logic active;
    logic prev;
    logic [OC_W-1:0] oc;
    logic [DELAY_W-1:0] pend;
  } chan_state_t;

  // Message framing toward the CAN controller
  typedef struct packed {
    logic start;
    logic last;
    logic code_valid;
    logic prev_list;
    logic multipacket;
    logic [OC_W-1:0] count;
    logic [31:0] code;
  } msg_t;

  // Definition defaults: supply window, temperature limit, timeout state
  function automatic def_cfg_t def_reset(input int idx);
    def_cfg_t d;
    d = '{enable: 1'b0, source: SRC_SUPPLY, style: STYLE_MINMAX};
    if (idx == 0) d = '{enable: 1'b1, source: SRC_SUPPLY, style: STYLE_MINMAX};
    if (idx == 1) d = '{enable: 1'b1, source: SRC_TEMP, style: STYLE_ABS};
    if (idx == 2) d = '{enable: 1'b1, source: SRC_COMM_TIMEOUT, style: STYLE_STATE};
    return d;
  endfunction

  // Channel defaults: thresholds set, parameter numbers left at zero
  function automatic chan_cfg_t chan_reset(input int idx);
    chan_cfg_t c;
    c = '0;
    c.fault_persist_delay = DEFAULT_DELAY;
    if (idx == 0) c.threshold = SUPPLY_LOW_TH;
    if (idx == 1) c.threshold = SUPPLY_HIGH_TH;
    if (idx == 4) c.threshold = TEMP_HIGH_TH;
    if (idx == 8) c.threshold = STATE_ON_TH;
    return c;
  endfunction

endpackage

// >>> design/fault_compare.sv
// Threshold comparison of one diagnostic definition for each fault style
`timescale 1ns/100ps
module fault_compare
  import fault_pkg::*;
(
  // Definition setup
  input wire logic enable,
  input wire fault_style_t style,
  input wire logic [NUM_TH-1:0][VAL_W-1:0] th,
  // Monitored value and per-threshold fault conditions
  input wire logic [VAL_W-1:0] value,
  output logic [NUM_TH-1:0] cond
);

  // Window style: channel 0 is the low side, channel 1 the high side; double style: channels 0-1 low, 2-3 high
  always_comb begin
    cond = 4'h0;
    if (enable) begin
      unique case (style)
        STYLE_MINMAX: begin
          cond[0] = value < th[0];
          cond[1] = value > th[1];
        end
        STYLE_ABS: begin
          cond[0] = value >= th[0];
        end
        STYLE_STATE: begin
          // Fixed one/zero threshold: any non-zero state is a fault
          cond[0] = value >= STATE_ON_TH;
        end
        STYLE_DOUBLE: begin
          cond[0] = value < th[0];
          cond[1] = value < th[1];
          cond[2] = value > th[2];
          cond[3] = value > th[3];
        end
      endcase
    end
  end

endmodule

// >>> design/fault_monitor.sv
// Diagnostic fault monitor and active/previous trouble-code message scheduler
//
// How it works
// - Code packs SPN, FMI, zero CM, count.
// - Previous-code list sent only on request.
// - Previous codes cleared only on request.
// - Active codes cleared on request, or when fault ends unless sticky.
// - Sixteen independently configured diagnostic definitions.
// - Defaults watch supply, temperature, timeouts.
// - Four styles: window, absolute, state, double.
// - Window style: fault outside low/high.
// - Absolute style: fault at or above threshold.
// - State style: fixed one/zero threshold.
// - Double window: four thresholds, own status.
// - Supply and temperature shutdown flags kept.
// - Empty active message once per second.
// - New active code sends message immediately.
// - Last code clearing sends empty message.
// - Several active codes use multipacket transfer.
// - No active-code broadcast for five seconds.
// - Fault must persist delay before going active.
// - Clearing ends activity unless sticky option.
// - Zero SPN never reports; change clears count.
`timescale 1ns/100ps
module fault_monitor
  import fault_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,      // Clock cycles per evaluation tick
  parameter int PERIOD_LEN = PERIOD_TICKS,   // Ticks between periodic messages
  parameter int STARTUP_LEN = STARTUP_TICKS  // Ticks of broadcast hold-off
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Monitored values
  input wire logic [NUM_SRC-1:0][VAL_W-1:0] mon_value,
  // Configuration writes
  input wire logic cfg_defaults,
  input wire logic cfg_def_we,
  input wire logic cfg_chan_we,
  input wire logic [3:0] cfg_def,
  input wire logic [1:0] cfg_chan,
  input wire def_cfg_t cfg_def_data,
  input wire chan_cfg_t cfg_chan_data,
  // Diagnostic requests received from the network
  input wire logic req_prev_list,
  input wire logic req_clear_prev,
  input wire logic req_clear_active,
  // Message output toward the CAN controller
  output msg_t msg,
  // Shutdown flags
  output logic supply_fault,
  output logic temp_fault
);

  typedef enum logic [1:0] {SCAN_IDLE, SCAN_RUN, SCAN_END} scan_t;

  // Whole module state
  typedef struct packed {
    def_cfg_t [NUM_DEF-1:0] dcfg;     // Definition setup
    chan_cfg_t [NUM_CH-1:0] ccfg;     // Threshold reporting setup
    chan_state_t [NUM_CH-1:0] ch;     // Fault state per channel
    logic [CNT_W-1:0] tick_cnt;       // Cycle divider for the tick
    logic [CNT_W-1:0] period_cnt;     // Ticks since the last active-code message
    logic [CNT_W-1:0] startup_cnt;    // Ticks since reset
    logic started;                    // Hold-off over
    logic any_active;                 // Active codes existed at the last tick
    logic active_pend;                // Active-code message waiting
    logic prev_pend;                  // Previous-code message waiting
    scan_t scan;                      // Message walker state
    logic scan_prev;                  // Walker is emitting the previous list
    logic [5:0] scan_idx;             // Channel being walked
    msg_t msg;                        // Registered message outputs
    logic supply_fault;
    logic temp_fault;
  } state_t;

  state_t s;
  state_t next_s;
  logic [NUM_CH-1:0] cond;            // Raw fault condition per channel
  logic tick;                         // One-cycle evaluation enable
  logic new_active;                   // A code went active this tick
  logic [OC_W-1:0] active_now;        // Active codes after this cycle's update
  logic [5:0] cidx;                   // Channel index of a configuration write

  // Reset value: zero state plus default configuration
  function automatic state_t reset_state();
    state_t r;
    r = '0;
    for (int i = 0; i < NUM_DEF; i++) begin
      r.dcfg[i] = def_reset(i);
    end
    for (int i = 0; i < NUM_CH; i++) begin
      r.ccfg[i] = chan_reset(i);
    end
    return r;
  endfunction

  // A channel reports only when its definition uses it and its SPN is set
  function automatic logic reportable(input state_t st, input int i);
    logic used;
    used = st.dcfg[i / NUM_TH].enable;
    unique case (st.dcfg[i / NUM_TH].style)
      STYLE_MINMAX: used = used && ((i % NUM_TH) < 2);
      STYLE_ABS: used = used && ((i % NUM_TH) == 0);
      STYLE_STATE: used = used && ((i % NUM_TH) == 0);
      STYLE_DOUBLE: used = used;
    endcase
    return used && (st.ccfg[i].fault_parameter_number_setting != 19'h00000);
  endfunction

  // Number of codes in the active or previous list
  function automatic logic [OC_W-1:0] count_codes(input state_t st, input logic prev_list);
    logic [OC_W-1:0] n;
    n = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (reportable(st, i) && (prev_list ? (st.ch[i].prev && !st.ch[i].active)
                                          : st.ch[i].active)) begin
        n = n + 7'h01;
      end
    end
    return n;
  endfunction

  // Four-byte trouble code, first byte in the low bits
  function automatic logic [31:0] make_code(input chan_cfg_t c, input logic [OC_W-1:0] oc);
    return {CONV_METHOD, oc, c.fault_parameter_number_setting[18:16], c.fmi,
            c.fault_parameter_number_setting[15:8],
            c.fault_parameter_number_setting[7:0]};
  endfunction

  // One comparator per definition
  genvar g;
  generate
    for (g = 0; g < NUM_DEF; g++) begin : gen_def
      fault_compare u_cmp (
        .enable(s.dcfg[g].enable),
        .style(s.dcfg[g].style),
        .th({s.ccfg[g*NUM_TH+3].threshold, s.ccfg[g*NUM_TH+2].threshold,
             s.ccfg[g*NUM_TH+1].threshold, s.ccfg[g*NUM_TH].threshold}),
        .value(mon_value[s.dcfg[g].source]),
        .cond(cond[g*NUM_TH +: NUM_TH])
      );
    end
  endgenerate

  assign tick = (s.tick_cnt == CNT_W'(TICK_LEN - 1));
  assign cidx = {cfg_def, cfg_chan};

  // Next-state logic: configuration, requests, tick evaluation, scheduler, walker
  always_comb begin
    next_s = s;
    new_active = 1'b0;
    next_s.msg.start = 1'b0;
    next_s.msg.last = 1'b0;
    next_s.msg.code_valid = 1'b0;
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + 16'h0001;

    // Configuration writes; a restore of defaults wins over a single write
    if (cfg_defaults) begin
      next_s.dcfg = reset_state().dcfg;
      next_s.ccfg = reset_state().ccfg;
    end else begin
      if (cfg_def_we) begin
        next_s.dcfg[cfg_def] = cfg_def_data;
      end
      if (cfg_chan_we) begin
        if (cfg_chan_data.fault_parameter_number_setting !=
            s.ccfg[cidx].fault_parameter_number_setting) begin
          next_s.ch[cidx] = '0;
        end
        next_s.ccfg[cidx] = cfg_chan_data;
      end
    end

    // Clears act only on a request; applied before the tick so new faults survive
    for (int i = 0; i < NUM_CH; i++) begin
      if (req_clear_active) begin
        if (next_s.ch[i].active) begin
          next_s.ch[i].prev = 1'b1;
        end
        next_s.ch[i].active = 1'b0;
        next_s.ch[i].pend = '0;
      end else if (req_clear_prev && !next_s.ch[i].active) begin
        next_s.ch[i].prev = 1'b0;
        next_s.ch[i].oc = '0;
      end
    end

    // Per-tick evaluation of every channel
    if (tick) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (cond[i] && reportable(s, i)) begin
          if (!next_s.ch[i].active) begin
            if (next_s.ch[i].pend >= s.ccfg[i].fault_persist_delay) begin
              next_s.ch[i].active = 1'b1;
              next_s.ch[i].pend = '0;
              if (next_s.ch[i].oc != OC_MAX) begin
                next_s.ch[i].oc = next_s.ch[i].oc + 7'h01;
              end
              new_active = 1'b1;
            end else begin
              next_s.ch[i].pend = next_s.ch[i].pend + 16'h0001;
            end
          end
        end else begin
          // Condition gone: restart persistence, end activity unless held
          next_s.ch[i].pend = '0;
          if (next_s.ch[i].active && !s.ccfg[i].sticky_until_clear_option) begin
            next_s.ch[i].active = 1'b0;
            next_s.ch[i].prev = 1'b1;
          end
        end
      end
    end
    active_now = count_codes(next_s, 1'b0);

    // Shutdown flags follow the raw condition of supply and temperature watchers
    next_s.supply_fault = 1'b0;
    next_s.temp_fault = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cond[i] && s.dcfg[i / NUM_TH].source == SRC_SUPPLY) begin
        next_s.supply_fault = 1'b1;
      end
      if (cond[i] && s.dcfg[i / NUM_TH].source == SRC_TEMP) begin
        next_s.temp_fault = 1'b1;
      end
    end

    // Scheduler runs on the same tick, after the channels are updated
    if (tick) begin
      next_s.any_active = (active_now != '0);
      if (!s.started) begin
        // Hold-off: events during start-up are not broadcast
        if (s.startup_cnt >= CNT_W'(STARTUP_LEN - 1)) begin
          next_s.started = 1'b1;
        end
        next_s.startup_cnt = s.startup_cnt + 16'h0001;
      end else if (new_active) begin
        next_s.active_pend = 1'b1;
        next_s.period_cnt = '0;
      end else if (s.any_active && active_now == '0) begin
        next_s.active_pend = 1'b1;
        next_s.period_cnt = '0;
      end else if (s.period_cnt >= CNT_W'(PERIOD_LEN - 1)) begin
        next_s.active_pend = 1'b1;
        next_s.period_cnt = '0;
      end else begin
        next_s.period_cnt = s.period_cnt + 16'h0001;
      end
    end

    // Previous list is produced only when asked for
    if (req_prev_list) begin
      next_s.prev_pend = 1'b1;
    end

    // Message walker: start, one code per cycle, then end
    unique case (s.scan)
      SCAN_IDLE: begin
        if (s.active_pend || s.prev_pend) begin
          // Active message has priority over a requested previous list
          next_s.scan_prev = !s.active_pend;
          if (s.active_pend) begin
            next_s.active_pend = 1'b0;
          end else begin
            next_s.prev_pend = req_prev_list;
          end
          next_s.msg.start = 1'b1;
          next_s.msg.prev_list = !s.active_pend;
          next_s.msg.count = count_codes(s, !s.active_pend);
          next_s.msg.multipacket = (count_codes(s, !s.active_pend) > 7'h01);
          next_s.scan_idx = '0;
          next_s.scan = SCAN_RUN;
        end
      end
      SCAN_RUN: begin
        if (reportable(s, int'(s.scan_idx)) &&
            (s.scan_prev ? (s.ch[s.scan_idx].prev && !s.ch[s.scan_idx].active)
                         : s.ch[s.scan_idx].active)) begin
          next_s.msg.code_valid = 1'b1;
          next_s.msg.code = make_code(s.ccfg[s.scan_idx], s.ch[s.scan_idx].oc);
        end
        next_s.scan_idx = s.scan_idx + 6'h01;
        if (s.scan_idx == 6'h3F) begin
          next_s.scan = SCAN_END;
        end
      end
      SCAN_END: begin
        next_s.msg.last = 1'b1;
        next_s.scan = SCAN_IDLE;
      end
      default: begin
        next_s.scan = SCAN_IDLE;
      end
    endcase
  end

  // State register; reset loads the default configuration constant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  assign msg = s.msg;
  assign supply_fault = s.supply_fault;
  assign temp_fault = s.temp_fault;

endmodule

// >>> bench/fault_monitor_checker.sv
// Concurrent checks on the message port of the fault monitor
`timescale 1ns/100ps
module fault_monitor_checker
  import fault_pkg::*;
#(
  parameter int TICK_LEN = 10,    // Cycles per tick, as handed on by the bind
  parameter int PERIOD_LEN = 20,  // Ticks per periodic message
  parameter int STARTUP_LEN = 30  // Ticks of hold-off
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request and message stream
  input wire logic req_prev_list,
  input wire msg_t msg
);
  localparam int HOLD_CYC = STARTUP_LEN * TICK_LEN;      // Hold-off in clock cycles
  localparam int GAP_MAX = PERIOD_LEN * TICK_LEN + 140;  // Slack for a walk that is waited on
  logic [15:0] since_rst;  // Cycles since reset, saturating
  logic prev_asked;        // A list request still unanswered
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Saturate so a long run cannot wrap back under the hold-off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_rst <= '0;
      prev_asked <= 1'b0;
    end else begin
      if (since_rst != 16'hFFFF) begin
        since_rst <= since_rst + 16'h0001;
      end
      // A request in the start cycle of a list arms the next one
      prev_asked <= req_prev_list || (prev_asked && !(msg.start && msg.prev_list));
    end
  end
  property p_frame;
    msg.start |=> (!msg.start throughout (##64 msg.last));
  endproperty
  a_frame: assert property (p_frame) else $error("message walk length wrong");
  property p_cm;
    msg.code_valid |-> (msg.code[31] == CONV_METHOD);
  endproperty
  a_cm: assert property (p_cm) else $error("conversion method bit set");
  property p_holdoff;
    msg.start |-> (since_rst >= HOLD_CYC);
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("message during hold-off");
  property p_multi;
    msg.start |-> (msg.multipacket == (msg.count > 7'h01));
  endproperty
  a_multi: assert property (p_multi) else $error("multipacket flag wrong");
  property p_empty;
    msg.code_valid |-> (msg.count != 7'h00);
  endproperty
  a_empty: assert property (p_empty) else $error("code in empty message");
  property p_period;
    (msg.start && !msg.prev_list) |-> ##[66:GAP_MAX] (msg.start && !msg.prev_list);
  endproperty
  a_period: assert property (p_period) else $error("periodic message missing");
  property p_prev_req;
    (msg.start && msg.prev_list) |-> prev_asked;
  endproperty
  a_prev_req: assert property (p_prev_req) else $error("unrequested list");
  property p_hold;
    !msg.start |-> ($stable(msg.prev_list) && $stable(msg.count));
  endproperty
  a_hold: assert property (p_hold) else $error("header changed mid message");
endmodule

bind fault_monitor fault_monitor_checker #(.TICK_LEN(TICK_LEN), .PERIOD_LEN(PERIOD_LEN),
  .STARTUP_LEN(STARTUP_LEN)) chk (.clk(clk), .rst(rst), .req_prev_list(req_prev_list),
  .msg(msg));

// >>> bench/msg_sink.sv
// Behavioural CAN-side model that collects whole trouble-code messages
`timescale 1ns/100ps
module msg_sink
  import fault_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Message stream
  input wire msg_t msg,
  // Summary of the last complete message
  output int n_msg,
  output int n_code,
  output logic [OC_W-1:0] got_count,
  output logic got_prev,
  output logic got_multi,
  output logic [31:0] first_code
);
  int run_codes;          // Codes seen in the walk under way
  logic [31:0] run_first; // First code of the walk under way
  // Publish only at the last cycle, so a half walk is never judged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_msg <= 0;
      n_code <= 0;
      run_codes <= 0;
      run_first <= '0;
      got_count <= '0;
      got_prev <= 1'b0;
      got_multi <= 1'b0;
      first_code <= '0;
    end else begin
      if (msg.start) begin
        run_codes <= 0;
        run_first <= '0;
      end
      if (msg.code_valid) begin
        run_codes <= run_codes + 1;
        if (run_codes == 0) begin
          run_first <= msg.code;
        end
      end
      if (msg.last) begin
        n_msg <= n_msg + 1;
        n_code <= run_codes;
        got_count <= msg.count;
        got_prev <= msg.prev_list;
        got_multi <= msg.multipacket;
        first_code <= run_first;
      end
    end
  end
endmodule

// >>> bench/tb_fault_monitor.sv
// Self-checking bench for the fault monitor and trouble-code reporter
`timescale 1ns/100ps
module tb_fault_monitor
  import fault_pkg::*;
;
  localparam logic [18:0] SPN_A = 19'h4ABCD; // Temperature code
  localparam logic [18:0] SPN_B = 19'h00321; // Timeout code
  localparam logic [18:0] SPN_C = 19'h4ABCE; // Renumbered temperature code
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_SRC-1:0][VAL_W-1:0] mon_value;
  logic cfg_chan_we, req_prev_list, req_clear_prev, req_clear_active;
  logic cfg_defaults, cfg_def_we;
  def_cfg_t cfg_def_data;
  logic [3:0] cfg_def;
  logic [1:0] cfg_chan;
  chan_cfg_t cfg_chan_data;
  msg_t msg;
  logic supply_fault, temp_fault;
  int n_msg, n_code;
  logic [OC_W-1:0] got_count;
  logic got_prev, got_multi;
  logic [31:0] first_code;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // Short counts keep the run small; expectations follow from them
  fault_monitor #(.TICK_LEN(10), .PERIOD_LEN(20), .STARTUP_LEN(30)) dut (.clk(clk), .rst(rst),
    .mon_value(mon_value), .cfg_defaults(cfg_defaults), .cfg_def_we(cfg_def_we),
    .cfg_chan_we(cfg_chan_we), .cfg_def(cfg_def), .cfg_chan(cfg_chan),
    .cfg_def_data(cfg_def_data), .cfg_chan_data(cfg_chan_data),
    .req_prev_list(req_prev_list), .req_clear_prev(req_clear_prev),
    .req_clear_active(req_clear_active), .msg(msg), .supply_fault(supply_fault),
    .temp_fault(temp_fault));
  msg_sink sink (.clk(clk), .rst(rst), .msg(msg), .n_msg(n_msg), .n_code(n_code),
    .got_count(got_count), .got_prev(got_prev), .got_multi(got_multi), .first_code(first_code));
  always #50 clk = ~clk;
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      $display("BAD t=%0t timeout got=%h exp=%h", $time, cyc, 0);
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("tests=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Byte order: spn low, spn mid, spn top with fmi, zero bit with count
  function automatic logic [31:0] exp_code(logic [18:0] spn, logic [4:0] fmi, logic [6:0] oc);
    return {1'b0, oc, spn[18:16], fmi, spn[15:8], spn[7:0]};
  endfunction
  task automatic set_val(input int idx, input logic [VAL_W-1:0] v);
    @(posedge clk);
    mon_value[idx] <= v;
  endtask
  task automatic wr_chan(input int d, input int c, input logic [VAL_W-1:0] th,
      input logic [18:0] spn, input logic [4:0] fmi, input logic [15:0] dly, input logic stk);
    @(posedge clk);
    cfg_def <= 4'(d);
    cfg_chan <= 2'(c);
    cfg_chan_data <= '{th, spn, fmi, dly, stk};
    cfg_chan_we <= 1'b1;
    @(posedge clk);
    cfg_chan_we <= 1'b0;
  endtask
  // One-cycle request pulse: 0 list, 1 clear previous, 2 clear active
  task automatic req(input int which);
    @(posedge clk);
    req_prev_list <= (which == 0);
    req_clear_prev <= (which == 1);
    req_clear_active <= (which == 2);
    @(posedge clk);
    {req_prev_list, req_clear_prev, req_clear_active} <= 3'h0;
  endtask
  // Wait for the next whole message, bounded
  task automatic wait_msg(input int lim);
    int n0;
    int k;
    n0 = n_msg;
    k = 0;
    while (n_msg == n0 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(32'(n_msg != n0), 32'h1);
  endtask
  task automatic test_holdoff();
    repeat (295) @(posedge clk);
    #1;
    check(32'(n_msg), 32'h0);
    // First idle message comes one period after the hold-off ends
    wait_msg(300);
    check({17'h0, got_count, n_code[7:0]}, 32'h0);
    $display("holdoff and idle message done");
  endtask
  task automatic test_flags();
    logic [VAL_W-1:0] v[6] = '{16'h2327, 16'h2328, 16'h7530, 16'h7531, 16'h0054, 16'h0055};
    logic e[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 6; i++) begin
      set_val(i / 4, v[i]);
      repeat (3) @(posedge clk);
      #1;
      check(32'(i < 4 ? supply_fault : temp_fault), 32'(e[i]));
    end
    // Disable the temperature definition, then restore defaults
    @(posedge clk);
    cfg_def <= 4'h1;
    cfg_def_data <= '{1'b0, SRC_TEMP, STYLE_ABS};
    cfg_def_we <= 1'b1;
    @(posedge clk);
    cfg_def_we <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(32'(temp_fault), 32'h0);
    @(posedge clk);
    cfg_defaults <= 1'b1;
    @(posedge clk);
    cfg_defaults <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(32'(temp_fault), 32'h1);
    set_val(0, 16'h4000);
    set_val(1, 16'h0020);
    $display("shutdown flags done");
  endtask
  task automatic test_new_code();
    wr_chan(1, 0, TEMP_HIGH_TH, SPN_A, 5'h10, 16'h0003, 1'b0);
    wait_msg(250);
    set_val(1, 16'h0060);
    repeat (20) @(posedge clk);
    #1;
    // A code that skipped the delay would already have started a message
    check(32'(msg.count), 32'h0);
    wait_msg(100);
    check(first_code, exp_code(SPN_A, 5'h10, 7'h01));
    check({got_count, got_multi}, {7'h01, 1'b0});
    $display("new code done");
  endtask
  task automatic test_multi();
    wr_chan(2, 0, STATE_ON_TH, SPN_B, 5'h13, 16'h0000, 1'b0);
    wait_msg(250);
    set_val(2, 16'h0001);
    wait_msg(90);
    check({got_count, got_multi}, {7'h02, 1'b1});
    check(32'(n_code), 32'h2);
    check(first_code, exp_code(SPN_A, 5'h10, 7'h01));
    $display("multipacket done");
  endtask
  task automatic test_last_clear();
    wait_msg(250);
    set_val(1, 16'h0020);
    set_val(2, 16'h0000);
    wait_msg(90);
    check({got_count, got_prev}, {7'h00, 1'b0});
    wait_msg(250);
    req(0);
    wait_msg(80);
    check({got_count, got_prev}, {7'h02, 1'b1});
    wait_msg(250);
    req(1);
    req(0);
    wait_msg(80);
    check({got_count, got_prev}, {7'h00, 1'b1});
    $display("clear and previous list done");
  endtask
  task automatic test_sticky();
    // Leave a count of one behind, so the renumbering has something to clear
    wait_msg(250);
    set_val(1, 16'h0060);
    wait_msg(120);
    set_val(1, 16'h0020);
    wait_msg(90);
    wr_chan(1, 0, TEMP_HIGH_TH, SPN_C, 5'h10, 16'h0000, 1'b1);
    wait_msg(250);
    set_val(1, 16'h0060);
    wait_msg(90);
    check(first_code, exp_code(SPN_C, 5'h10, 7'h01));
    set_val(1, 16'h0020);
    wait_msg(250);
    check(32'(got_count), 32'h1);
    req(2);
    wait_msg(250);
    check(32'(got_count), 32'h0);
    $display("sticky and clear active done");
  endtask
  initial begin
    mon_value = '0;
    mon_value[0] = 16'h4000;
    mon_value[1] = 16'h0020;
    {cfg_chan_we, req_prev_list, req_clear_prev, req_clear_active} = 4'h0;
    {cfg_defaults, cfg_def_we} = 2'h0;
    cfg_def_data = '0;
    cfg_def = 4'h0;
    cfg_chan = 2'h0;
    cfg_chan_data = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_holdoff();
    test_flags();
    test_new_code();
    test_multi();
    test_last_clear();
    test_sticky();
    print_verdict();
  end
endmodule
